// *** cii_pkg.sv ***
// Shared constants and carrier types of the contour increment interpolator.
// Assumes a 32-bit AHB-Lite register bus and a servo sample tick on the same clock.
package cii_pkg;
    localparam int          AXES          = 8;
    localparam int          INC_W         = 16;
    localparam int          POS_W         = 32;
    localparam int          EXP_W         = 4;
    localparam int          QUEUE_DEPTH   = 511;
    // Register byte offsets
    localparam logic [7:0]  OFS_AXIS_SEL  = 8'h00;
    localparam logic [7:0]  OFS_COMMIT    = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  OFS_INC_BASE  = 8'h20;
    // Commit word fields
    localparam int          COMMIT_EXP_LSB = 0;
    localparam int          COMMIT_HAS_EXP = 8;
    // Status word fields
    localparam int          ST_ACTIVE     = 0;
    localparam int          ST_WAITING    = 1;
    localparam int          ST_RUNNING    = 2;
    localparam int          ST_FREE_LSB   = 16;
    // Interrupt bits
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_END       = 0;
    localparam int          IRQ_STARVE    = 1;
    localparam int          IRQ_REJECT    = 2;
    // Exponent and increment limits
    localparam logic [3:0]  EXP_MIN       = 4'h1;
    localparam logic [3:0]  EXP_MAX       = 4'h8;
    localparam logic [3:0]  EXP_RESET     = 4'h1;
    localparam int          INC_LIMIT     = 32000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef logic [AXES-1:0][INC_W-1:0] cii_inc_t;

    // One queued segment: increments plus the resolved exponent
    typedef struct packed {
        logic [EXP_W-1:0] exp;
        cii_inc_t         inc;
    } cii_entry_s;

    typedef logic [AXES-1:0][POS_W-1:0] cii_pos_t;
endpackage

// *** cii_queue.sv ***
// Flip-flop FIFO holding contour segments in arrival order.
// Assumes one clock, a clock enable and an active-low synchronous-released reset.
`timescale 1ns/1ps
module cii_queue
    import cii_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int WIDTH = $bits(cii_entry_s),
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [CW-1:0]         count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    // Elaboration check on the depth
    if (DEPTH < 2) begin
        $error("cii_queue: DEPTH must be at least 2");
    end


    // Full stops the writer; nothing is overwritten
    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count, consumed in arrival order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wrap_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= wrap_inc(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// *** cii_top.sv ***
// Contour increment interpolator: AHB-Lite registers, segment queue, per-sample interpolation.
// Assumes sample_tick is a one-cycle pulse from logic on clk, at most one per three cycles.
//
// Function
// - Axis select names one to eight contouring axes
// - Unselected axes keep positions, free for others
// - Segment lasts two-to-exponent samples, exponent 1..8
// - Linear interpolation, one point every sample
// - Entry may carry exponent, sticks for later
// - Queue of 511, free count readable
// - All-zero entry, exponent zero, ends contour mode
// - Empty queue while active: wait, no points
// - Malformed entry rejected with error flag
// - Entry without exponent uses previous exponent
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cii_top
    import cii_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        sample_tick,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output cii_pos_t         pos_cmd,
    output logic [AXES-1:0]  point_valid,
    output logic [AXES-1:0]  contour_axes,
    output logic             contour_active,
    output logic             irq
);
    localparam int CW = $clog2(DEPTH + 1);

    // Elaboration check: the free count must fit its status field
    if (DEPTH < 2 || DEPTH > 4095) begin
        $error("cii_top: DEPTH out of range");
    end


    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_RUN
    } cii_seq_e;

    logic [1:0]           rst_pipe;
    logic                 rst_n;
    logic                 dp_valid;
    logic                 dp_write;
    logic [7:0]           dp_addr;
    cii_inc_t             inc_stage;
    logic [EXP_W-1:0]     last_exp;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [IRQ_W-1:0]     irq_evt;
    logic                 addr_ok;
    logic                 commit_dp;
    logic                 has_exp;
    logic [EXP_W-1:0]     wr_exp;
    logic                 inc_bad;
    logic                 inc_zero;
    logic                 is_end;
    logic                 entry_bad;
    cii_entry_s           new_entry;
    logic                 q_in_valid;
    logic                 q_in_ready;
    logic                 q_out_valid;
    logic                 q_out_ready;
    cii_entry_s           q_out;
    logic [CW-1:0]        q_count;
    logic [CW-1:0]        free_count;
    cii_seq_e             seq;
    cii_entry_s           seg;
    logic [8:0]           step;
    cii_pos_t             base;
    logic                 seg_last;
    logic [31:0]          rd_mux;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Share of increment d reached after k of 2^n samples
    function automatic logic [POS_W-1:0] interp(input logic [INC_W-1:0] d,
                                                 input logic [8:0] k,
                                                 input logic [EXP_W-1:0] n);
        logic signed [25:0] p;
        p = 26'($signed(d)) * 26'($signed({1'b0, k}));
        return POS_W'(p >>> n);
    endfunction

    // Signed increment outside the allowed band
    function automatic logic out_of_band(input logic [INC_W-1:0] d);
        return ($signed(d) > INC_LIMIT) || ($signed(d) < -INC_LIMIT);
    endfunction

    // Entry decode and validation from the commit word
    assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign commit_dp = dp_valid && dp_write && (dp_addr == OFS_COMMIT);
    assign has_exp   = hwdata[COMMIT_HAS_EXP];
    assign wr_exp    = hwdata[COMMIT_EXP_LSB +: EXP_W];
    always_comb begin
        inc_bad  = 1'b0;
        inc_zero = 1'b1;
        for (int a = 0; a < AXES; a++) begin
            if (out_of_band(inc_stage[a])) begin
                inc_bad = 1'b1;
            end
            if (inc_stage[a] != '0) begin
                inc_zero = 1'b0;
            end
        end
    end
    assign is_end    = inc_zero && has_exp && (wr_exp == '0);
    assign entry_bad = inc_bad || (has_exp && !is_end
                       && (wr_exp < EXP_MIN || wr_exp > EXP_MAX));
    assign new_entry.inc = inc_stage;
    assign new_entry.exp = has_exp ? wr_exp : last_exp;
    // Push only during the stalled data phase of a good commit
    assign q_in_valid = ce && commit_dp && !hreadyout && !entry_bad && contour_active;

    // Bus address phase capture and wait-state control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid  <= 1'b0;
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            if (commit_dp && !hreadyout) begin
                // Hold the master while the queue is full
                if (q_in_ready || entry_bad || !contour_active) begin
                    hreadyout <= 1'b1;
                    dp_valid  <= 1'b0;
                end
            end else if (addr_ok) begin
                dp_valid  <= 1'b1;
                dp_write  <= hwrite;
                dp_addr   <= haddr[7:0];
                hreadyout <= !(hwrite && haddr[7:0] == OFS_COMMIT);
            end else if (hreadyout) begin
                dp_valid <= 1'b0;
            end
        end
    end

    // Read data, loaded at the address phase
    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            OFS_AXIS_SEL: rd_mux[AXES-1:0] = contour_axes;
            OFS_COMMIT:   rd_mux[EXP_W-1:0] = last_exp;
            OFS_STATUS: begin
                rd_mux[ST_ACTIVE]  = contour_active;
                rd_mux[ST_WAITING] = (seq == SEQ_WAIT);
                rd_mux[ST_RUNNING] = (seq == SEQ_RUN);
                rd_mux[ST_FREE_LSB +: CW] = free_count;
            end
            OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
            OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
            default: begin
                for (int a = 0; a < AXES; a++) begin
                    if (haddr[7:0] == OFS_INC_BASE + 8'(4 * a)) begin
                        rd_mux[INC_W-1:0] = inc_stage[a];
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0;
        end else if (ce && addr_ok && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // Staged increments, mask and remembered exponent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inc_stage <= '0;
            irq_mask  <= '0;
            last_exp  <= EXP_RESET;
        end else if (ce) begin
            if (dp_valid && dp_write && hreadyout) begin
                for (int a = 0; a < AXES; a++) begin
                    if (dp_addr == OFS_INC_BASE + 8'(4 * a)) begin
                        inc_stage[a] <= hwdata[INC_W-1:0];
                    end
                end
                if (dp_addr == OFS_IRQ_MASK) begin
                    irq_mask <= hwdata[IRQ_W-1:0];
                end
            end
            if (q_in_valid && q_in_ready && has_exp && !is_end) begin
                last_exp <= wr_exp;
            end
        end
    end

    cii_queue #(
        .DEPTH     (DEPTH),
        .WIDTH     ($bits(cii_entry_s)),
        .CW        (CW)
    ) u_queue (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (q_in_valid),
        .in_ready  (q_in_ready),
        .in_data   (new_entry),
        .out_valid (q_out_valid),
        .out_ready (q_out_ready),
        .out_data  (q_out),
        .count     (q_count)
    );
    assign free_count  = CW'(DEPTH) - q_count;
    assign q_out_ready = (seq == SEQ_WAIT);
    assign seg_last    = (step == 9'(1 << seg.exp) - 9'h1);

    // Segment sequencer and mode control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq            <= SEQ_IDLE;
            seg            <= '0;
            step           <= 9'h0;
            contour_active <= 1'b0;
            contour_axes   <= '0;
            irq_evt        <= '0;
        end else if (ce) begin
            irq_evt <= '0;
            if (dp_valid && dp_write && hreadyout && dp_addr == OFS_AXIS_SEL) begin
                // Nonzero selection enters contour mode
                contour_axes   <= hwdata[AXES-1:0];
                contour_active <= (hwdata[AXES-1:0] != '0);
                seq            <= (hwdata[AXES-1:0] != '0) ? SEQ_WAIT : SEQ_IDLE;
            end else begin
                case (seq)
                    SEQ_IDLE: begin
                        contour_active <= 1'b0;
                    end
                    SEQ_WAIT: begin
                        if (q_out_valid) begin
                            if (q_out.exp == '0) begin
                                seq                <= SEQ_IDLE;
                                contour_active     <= 1'b0;
                                irq_evt[IRQ_END]   <= 1'b1;
                            end else begin
                                seg  <= q_out;
                                step <= 9'h0;
                                seq  <= SEQ_RUN;
                            end
                        end
                    end
                    SEQ_RUN: begin
                        if (sample_tick) begin
                            step <= step + 9'h1;
                            if (seg_last) begin
                                seq <= SEQ_WAIT;
                                // Nothing queued at segment end means a stall
                                irq_evt[IRQ_STARVE] <= !q_out_valid;
                            end
                        end
                    end
                    default: begin
                        seq <= SEQ_IDLE;
                    end
                endcase
            end
            if (commit_dp && !hreadyout && (entry_bad || !contour_active)) begin
                irq_evt[IRQ_REJECT] <= 1'b1;
            end
        end
    end

    // Position points, one per sample for selected axes only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_cmd     <= '0;
            base        <= '0;
            point_valid <= '0;
        end else if (ce) begin
            point_valid <= '0;
            if (seq == SEQ_RUN && sample_tick) begin
                for (int a = 0; a < AXES; a++) begin
                    if (contour_axes[a]) begin
                        pos_cmd[a] <= base[a] + interp(seg.inc[a], step + 9'h1,
                                                       seg.exp);
                        point_valid[a] <= 1'b1;
                        if (seg_last) begin
                            base[a] <= base[a] + interp(seg.inc[a], step + 9'h1,
                                                        seg.exp);
                        end
                    end
                end
            end
        end
    end

    // Sticky interrupt status, cleared by a read, set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else if (ce) begin
            if (addr_ok && !hwrite && haddr[7:0] == OFS_IRQ_STAT) begin
                irq_stat <= irq_evt;
            end else begin
                irq_stat <= irq_stat | irq_evt;
            end
            irq <= |(irq_stat & irq_mask);
        end
    end
endmodule

// *** cii_monitor.sv ***
// Concurrent checks on the ports of the contour increment interpolator.
// Assumes a single bus slave, so hready is the slave's own hreadyout.
`timescale 1ns/1ps
module cii_monitor
    import cii_pkg::*;
(
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            ce,
    input wire logic            hsel,
    input wire logic [31:0]     haddr,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic [31:0]     hwdata,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire cii_pos_t        pos_cmd,
    input wire logic [AXES-1:0] point_valid,
    input wire logic [AXES-1:0] contour_axes,
    input wire logic            contour_active
);
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Address phase taken by the slave
    sequence seq_take;
        hsel && hready && ce && htrans == HTRANS_NONSEQ;
    endsequence
    // Nonzero axis selection carried through its data phase
    sequence seq_select;
        (hsel && hready && ce && htrans == HTRANS_NONSEQ && hwrite && haddr[7:0] == OFS_AXIS_SEL)
        ##1 (hready && hwdata[7:0] != 8'h00);
    endsequence

    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    AST_SELECT_ENTERS: assert property (seq_select |-> ##[1:3] contour_active)
        else $error("axis selection did not enter contour mode");
    AST_COMMIT_STALL: assert property (seq_take ##0 (hwrite && haddr[7:0] == OFS_COMMIT)
        |=> !hreadyout)
        else $error("commit not held off for its push");
    AST_READ_NOWAIT: assert property (seq_take ##0 !hwrite |=> hreadyout)
        else $error("register read took wait states");
    AST_POINT_SPACING: assert property (|point_valid |=> (point_valid == 8'h00) [*2])
        else $error("two points inside one sample");
    AST_AXES_ONLY: assert property ((point_valid & ~contour_axes) == 8'h00)
        else $error("point issued on unselected axis");
    AST_POINT_ACTIVE: assert property (|point_valid |-> contour_active)
        else $error("point issued outside contour mode");
    AST_HOLD_POS: assert property (point_valid == 8'h00 |-> $stable(pos_cmd))
        else $error("position moved without a point");
    AST_END_QUIET: assert property ($fell(contour_active) |-> (point_valid == 8'h00) [*4])
        else $error("points after leaving contour mode");
endmodule
bind cii_top cii_monitor i_cii_monitor (.clk, .resetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .pos_cmd, .point_valid, .contour_axes, .contour_active);

// *** cii_host.sv ***
// Command source model: a single-transfer bus master that loads increments and commits entries.
// Assumes its tasks are entered just after a rising edge of clk.
`timescale 1ns/1ps
module cii_host
    import cii_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [31:0]      hwdata,
    output logic             timed_out
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        timed_out = 1'b0;
    end

    // One transfer; each phase held until hready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 3000);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 3000);
        rd = hrdata;
        hwdata <= ~wd; // Released data no longer shows the last value
        if (n >= 3000)
            timed_out = 1'b1;
    endtask

    // Loads axis 0 and axis 2 increments, then commits with the given exponent code
    task automatic entry(input logic [15:0] i0, input logic [15:0] i2, input logic [8:0] code);
        logic [31:0] rd;
        xfer(1'b1, OFS_INC_BASE, {16'h0000, i0}, rd);
        xfer(1'b1, OFS_INC_BASE + 8'h08, {16'h0000, i2}, rd);
        xfer(1'b1, OFS_COMMIT, {23'h0, code}, rd);
    endtask
endmodule

// *** test_contour_increment_interpolator.sv ***
// Self-checking bench for the contour increment interpolator, small queue depth.
// Assumes the command source model drives the bus and a sample tick every four cycles.
`timescale 1ns/1ps
module test_contour_increment_interpolator
    import cii_pkg::*;
;
    localparam int DEPTH_T = 4;
    logic              clk;
    logic              resetn = 1'b0;
    logic              sample_tick = 1'b0;
    logic [1:0]        tick_cnt = 2'h0;
    logic              hsel, hwrite, hreadyout, hresp, contour_active, irq, timed_out;
    logic [31:0]       haddr, hwdata, hrdata;
    logic [1:0]        htrans;
    cii_pos_t          pos_cmd;
    logic [AXES-1:0]   point_valid, contour_axes;
    logic [31:0]       first_pts [4];
    int                pulses = 0;
    int                stray = 0;
    int                fails = 0;
    int                samples_checked = 0;

    cii_top #(.DEPTH(DEPTH_T)) i_cii_top (.clk(clk), .resetn(resetn), .ce(1'b1),
        .sample_tick(sample_tick), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pos_cmd(pos_cmd), .point_valid(point_valid),
        .contour_axes(contour_axes), .contour_active(contour_active), .irq(irq));
    cii_host i_cii_host (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .timed_out(timed_out));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Sample tick every fourth cycle; points of axis 0 and strays on axis 1 counted
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        sample_tick <= (tick_cnt == 2'h3);
        if (point_valid[0] === 1'b1 && pulses < 4)
            first_pts[pulses] <= pos_cmd[0];
        if (point_valid[0] === 1'b1)
            pulses <= pulses + 1;
        if (point_valid[1] !== 1'b0)
            stray <= stray + 1;
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_cii_host.xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
        logic [31:0] x;
        i_cii_host.xfer(1'b0, a, 32'h0, x);
        check(what, e, x & m);
    endtask

    task automatic test_done;
        if (timed_out !== 1'b0)
            fails++;
        $display("Checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A bus wait that ran out ends the run at once
    always @(posedge timed_out) begin
        test_done();
    end

    // Bounded wait for a total count of axis 0 points, then ten quiet ticks
    task automatic wait_points(input int want);
        int n;
        n = 0;
        while (pulses < want && n < 12000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 12000) begin
            fails++;
            test_done();
        end else begin
            repeat (40) @(posedge clk);
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OFS_STATUS, 32'h01ff0007, 32'h00040000, "free after reset");
        rd_chk(8'h40, 32'hffffffff, 32'h0, "unmapped read");
        $display("Test reset done");
        // Refused commit: interrupt raised, cleared by read, then masked
        wr(OFS_IRQ_MASK, 32'h4);
        wr(OFS_COMMIT, 32'h102);
        repeat (2) @(posedge clk);
        check("irq raised", 32'h1, {31'h0, irq});
        rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4, "reject flag");
        repeat (2) @(posedge clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_COMMIT, 32'h102);
        repeat (2) @(posedge clk);
        check("irq masked", 32'h0, {31'h0, irq});
        rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4, "masked flag");
        $display("Test interrupt done");
        // Three segments on axes 0 and 2; axis 1 loaded but not selected
        wr(OFS_INC_BASE + 8'h04, 32'h64);
        wr(OFS_AXIS_SEL, 32'h05);
        repeat (3) @(posedge clk);
        check("active", 32'h1, {31'h0, contour_active});
        check("axes", 32'h05, {24'h0, contour_axes});
        i_cii_host.entry(16'h0030, 16'hfff0, 9'h102);
        i_cii_host.entry(16'h00f0, 16'hfff0, 9'h103);
        i_cii_host.entry(16'h0030, 16'hfff0, 9'h000);
        wait_points(20);
        check("point count", 32'd20, pulses);
        for (int k = 0; k < 4; k++)
            check("ramp point", 32'd12 * (k + 1), first_pts[k]);
        check("axis 0 end", 32'd336, pos_cmd[0]);
        check("axis 2 end", 32'hffffffd0, pos_cmd[2]);
        check("axis 1 still", 32'h0, pos_cmd[1]);
        check("axis 1 points", 32'h0, stray);
        rd_chk(OFS_STATUS, 32'h01ff0003, 32'h00040003, "waiting");
        rd_chk(OFS_COMMIT, 32'hf, 32'h3, "kept exponent");
        $display("Test segments done");
        // Malformed entries while active
        i_cii_host.entry(16'h7d01, 16'h0000, 9'h000);
        rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4, "range reject");
        i_cii_host.entry(16'h0001, 16'h0000, 9'h109);
        rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4, "exponent reject");
        rd_chk(OFS_STATUS, 32'h01ff0000, 32'h00040000, "nothing queued");
        $display("Test reject done");
        // Fill the queue behind a long segment; the sixth commit is held off
        i_cii_host.entry(16'h0002, 16'h0000, 9'h108);
        for (int e = 0; e < 4; e++)
            i_cii_host.entry(16'h0002, 16'h0000, 9'h000);
        rd_chk(OFS_STATUS, 32'h01ff0000, 32'h0, "queue full");
        i_cii_host.entry(16'h0002, 16'h0000, 9'h000);
        wait_points(20 + 6 * 256);
        check("full run points", 32'd1556, pulses);
        check("full run end", 32'd348, pos_cmd[0]);
        $display("Test full queue done");
        // End entry leaves contour mode; staged axis 1 cleared so every increment is zero
        wr(OFS_INC_BASE + 8'h04, 32'h0);
        i_cii_host.entry(16'h0000, 16'h0000, 9'h100);
        repeat (10) @(posedge clk);
        check("left mode", 32'h0, {31'h0, contour_active});
        rd_chk(OFS_IRQ_STAT, 32'h1, 32'h1, "end flag");
        rd_chk(OFS_STATUS, 32'h01ff0001, 32'h00040000, "all free");
        $display("Test end done");
        test_done();
    end
endmodule
